// File: hdl/opctl_pkg.sv
`default_nettype none
package opctl_pkg;

  // Command codes served by the byte slave
  localparam logic [7:0] CMD_PAGE = 8'h00;
  localparam logic [7:0] CMD_OPERATION = 8'h01;

  // Page selector values
  localparam logic [7:0] PAGE_FIRST = 8'h00;
  localparam logic [7:0] PAGE_SECOND = 8'h01;
  localparam logic [7:0] PAGE_BOTH = 8'hff;

  // Operation register layout and reset values
  localparam int ON_BIT = 7;
  localparam int MARGIN_MSB = 5;
  localparam int MARGIN_LSB = 2;
  localparam logic [7:0] OP_RESET = 8'h00;
  localparam logic [7:0] OP_WRITE_MASK = 8'hbf;
  localparam logic [7:0] PAGE_RESET = 8'h00;

  // Margin field codes
  localparam logic [3:0] MARGIN_OFF = 4'h0;
  localparam logic [3:0] MARGIN_LOW_IGN = 4'h5;
  localparam logic [3:0] MARGIN_LOW_ACT = 4'h6;
  localparam logic [3:0] MARGIN_HIGH_IGN = 4'h9;
  localparam logic [3:0] MARGIN_HIGH_ACT = 4'ha;
  localparam logic [1:0] FAULT_IGNORE = 2'h1;

  // Source select value that hands the voltage to the bus
  localparam logic [7:0] SRC_BUS = 8'h01;

  // Slave address default, arbitrary
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h40;

  // Bit count of one byte
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // One setpoint step per slew period
  localparam int CLK_PERIOD_NS = 10;
  localparam int SLEW_STEP_NS = 1000;
  localparam int SLEW_STEP_CYC = (SLEW_STEP_NS + CLK_PERIOD_NS - 1) /
                                 CLK_PERIOD_NS;
  localparam logic [7:0] SLEW_CNT_LAST = 8'(SLEW_STEP_CYC - 1);

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_ADDR = 4'b0001,
    ST_ADDR_ACK = 4'b0010,
    ST_CMD = 4'b0011,
    ST_CMD_ACK = 4'b0100,
    ST_WDATA = 4'b0101,
    ST_WDATA_ACK = 4'b0110,
    ST_RDATA = 4'b0111,
    ST_RDATA_ACK = 4'b1000,
    ST_WAIT = 4'b1001
  } bus_state_t;

  typedef struct packed {
    logic use_cmd;
    logic use_pin;
  } onoff_cfg_t;

  typedef struct packed {
    logic [7:0] nominal;
    logic [7:0] margin_low;
    logic [7:0] margin_high;
  } setpoint_t;

  typedef struct packed {
    logic conv_on;
    logic fault_ignore;
    logic ov_warn;
    logic [7:0] vout_target;
  } chan_out_t;

  localparam chan_out_t CHAN_RESET = '0;

  typedef struct packed {
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic [1:0] en_s1;
    logic [1:0] en_s2;
    logic uv_s1;
    logic uv_s2;
    bus_state_t state;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rw;
    logic [7:0] cmd;
    logic [7:0] page;
    logic [7:0] op_first;
    logic [7:0] op_second;
    logic sda_oe;
    logic [7:0] slew_cnt;
    logic tick;
  } slave_state_t;

  localparam slave_state_t SLAVE_RESET = '{
    scl_s: 3'h7, sda_s: 3'h7, en_s1: 2'h0, en_s2: 2'h0,
    uv_s1: 1'b0, uv_s2: 1'b0, state: ST_IDLE, cnt: 4'h0,
    sh: 8'h00, rw: 1'b0, cmd: 8'h00, page: PAGE_RESET,
    op_first: OP_RESET, op_second: OP_RESET, sda_oe: 1'b0,
    slew_cnt: 8'h00, tick: 1'b0};

endpackage
`default_nettype wire

// File: hdl/margin_channel.sv
`timescale 1ns/100ps
`default_nettype none
module margin_channel (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] op,
  input wire opctl_pkg::setpoint_t setpoint,
  input wire opctl_pkg::onoff_cfg_t cfg,
  input wire logic en_pin,
  input wire logic uvlo_ok,
  input wire logic bus_owns_vout,
  input wire logic tick,
  input wire logic ov_warn_clr,
  output opctl_pkg::chan_out_t st
);
  import opctl_pkg::*;

  chan_out_t st_q;
  chan_out_t st_d;
  logic [7:0] goal;
  logic active;

  always_comb begin
    st_d = st_q;
    goal = setpoint.nominal;
    active = 1'b0;
    case (op[MARGIN_MSB:MARGIN_LSB])
      MARGIN_LOW_IGN, MARGIN_LOW_ACT: begin
        goal = setpoint.margin_low;
        active = 1'b1;
      end
      MARGIN_HIGH_IGN, MARGIN_HIGH_ACT: begin
        goal = setpoint.margin_high;
        active = 1'b1;
      end
      default: begin
        goal = setpoint.nominal;
        active = 1'b0;
      end
    endcase
    // Without bus ownership the margin codes cannot move the rail
    if (!bus_owns_vout) begin
      goal = setpoint.nominal;
      active = 1'b0;
    end
    st_d.conv_on = uvlo_ok & (~cfg.use_cmd | op[ON_BIT]) &
                   (~cfg.use_pin | en_pin);
    st_d.fault_ignore = active &
                        (op[MARGIN_LSB+1:MARGIN_LSB] == FAULT_IGNORE);
    if (active && !st_d.fault_ignore && goal > setpoint.nominal) begin
      st_d.ov_warn = 1'b1;
    end else if (ov_warn_clr) begin
      st_d.ov_warn = 1'b0;
    end
    if (tick) begin
      if (st_q.vout_target < goal) begin
        st_d.vout_target = st_q.vout_target + 8'h01;
      end else if (st_q.vout_target > goal) begin
        st_d.vout_target = st_q.vout_target - 8'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_q <= CHAN_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign st = st_q;

endmodule // margin_channel
`default_nettype wire

// File: hdl/paged_operation_margin_control.sv
`timescale 1ns/100ps
`default_nettype none
module paged_operation_margin_control #(
  parameter logic [6:0] DEV_ADDR = opctl_pkg::DEV_ADDR_DEFAULT
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic scl,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic first_channel_enable_pin,
  input wire logic second_channel_enable_pin,
  input wire logic uvlo_ok,
  input wire opctl_pkg::onoff_cfg_t onoff_cfg,
  input wire logic [7:0] voltage_control_source_select,
  input wire opctl_pkg::setpoint_t setpoint_first,
  input wire opctl_pkg::setpoint_t setpoint_second,
  input wire logic ov_warn_clr,
  output opctl_pkg::chan_out_t chan_first,
  output opctl_pkg::chan_out_t chan_second
);
  import opctl_pkg::*;

  slave_state_t st_q;
  slave_state_t st_d;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic [7:0] wval;
  logic [7:0] rval;
  logic bus_owns;

  assign bus_owns = (voltage_control_source_select == SRC_BUS);
  assign wval = st_q.sh & OP_WRITE_MASK;

  always_comb begin
    if (st_q.cmd == CMD_PAGE) begin
      rval = st_q.page;
    end else if (st_q.page == PAGE_SECOND) begin
      rval = st_q.op_second;
    end else begin
      rval = st_q.op_first;
    end
  end

  always_comb begin
    st_d = st_q;
    // Two flops before any logic looks at scl, sda_i, the enable pins or uvlo_ok
    st_d.scl_s = {st_q.scl_s[1:0], scl};
    st_d.sda_s = {st_q.sda_s[1:0], sda_i};
    st_d.en_s1 = {second_channel_enable_pin, first_channel_enable_pin};
    st_d.en_s2 = st_q.en_s1;
    st_d.uv_s1 = uvlo_ok;
    st_d.uv_s2 = st_q.uv_s1;
    scl_rise = st_q.scl_s[1] & ~st_q.scl_s[2];
    scl_fall = ~st_q.scl_s[1] & st_q.scl_s[2];
    start_seen = st_q.scl_s[1] & st_q.scl_s[2] &
                 ~st_q.sda_s[1] & st_q.sda_s[2];
    stop_seen = st_q.scl_s[1] & st_q.scl_s[2] &
                st_q.sda_s[1] & ~st_q.sda_s[2];

    // Slew tick, free running
    st_d.tick = 1'b0;
    if (st_q.slew_cnt == SLEW_CNT_LAST) begin
      st_d.slew_cnt = 8'h00;
      st_d.tick = 1'b1;
    end else begin
      st_d.slew_cnt = st_q.slew_cnt + 8'h01;
    end

    if (start_seen) begin
      st_d.state = ST_ADDR;
      st_d.cnt = 4'h0;
      st_d.sda_oe = 1'b0;
    end else if (stop_seen) begin
      st_d.state = ST_IDLE;
      st_d.sda_oe = 1'b0;
    end else if (scl_rise) begin
      case (st_q.state)
        ST_ADDR, ST_CMD, ST_WDATA: begin
          st_d.sh = {st_q.sh[6:0], st_q.sda_s[1]};
          st_d.cnt = st_q.cnt + 4'h1;
        end
        ST_RDATA: begin
          st_d.cnt = st_q.cnt + 4'h1;
        end
        default: begin
          st_d.cnt = st_q.cnt;
        end
      endcase
    end else if (scl_fall) begin
      case (st_q.state)
        ST_ADDR: begin
          if (st_q.cnt == BYTE_BITS) begin
            if (st_q.sh[7:1] == DEV_ADDR) begin
              st_d.rw = st_q.sh[0];
              st_d.sda_oe = 1'b1;
              st_d.state = ST_ADDR_ACK;
            end else begin
              st_d.state = ST_WAIT;
            end
          end
        end
        ST_ADDR_ACK: begin
          st_d.cnt = 4'h0;
          if (st_q.rw) begin
            st_d.sh = rval;
            st_d.sda_oe = ~rval[7];
            st_d.state = ST_RDATA;
          end else begin
            st_d.sda_oe = 1'b0;
            st_d.state = ST_CMD;
          end
        end
        ST_CMD: begin
          if (st_q.cnt == BYTE_BITS) begin
            // Unserved commands are refused with a NACK
            if (st_q.sh == CMD_PAGE || st_q.sh == CMD_OPERATION) begin
              st_d.cmd = st_q.sh;
              st_d.sda_oe = 1'b1;
              st_d.state = ST_CMD_ACK;
            end else begin
              st_d.state = ST_WAIT;
            end
          end
        end
        ST_CMD_ACK: begin
          st_d.sda_oe = 1'b0;
          st_d.cnt = 4'h0;
          st_d.state = ST_WDATA;
        end
        ST_WDATA: begin
          if (st_q.cnt == BYTE_BITS) begin
            st_d.sda_oe = 1'b1;
            st_d.state = ST_WDATA_ACK;
            if (st_q.cmd == CMD_PAGE) begin
              st_d.page = st_q.sh;
            end else begin
              case (st_q.page)
                PAGE_FIRST: st_d.op_first = wval;
                PAGE_SECOND: st_d.op_second = wval;
                PAGE_BOTH: begin
                  st_d.op_first = wval;
                  st_d.op_second = wval;
                end
                default: st_d.op_first = st_q.op_first;
              endcase
            end
          end
        end
        ST_WDATA_ACK: begin
          // Extra bytes past the single data byte are not acked
          st_d.sda_oe = 1'b0;
          st_d.state = ST_WAIT;
        end
        ST_RDATA: begin
          if (st_q.cnt == BYTE_BITS) begin
            st_d.sda_oe = 1'b0;
            st_d.state = ST_RDATA_ACK;
          end else begin
            st_d.sh = {st_q.sh[6:0], 1'b0};
            st_d.sda_oe = ~st_q.sh[6];
          end
        end
        ST_RDATA_ACK: begin
          st_d.state = ST_WAIT;
        end
        default: begin
          st_d.sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_q <= SLAVE_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // Open drain: only ever pulls low
  assign sda_o = 1'b0;
  assign sda_oe = st_q.sda_oe;

  margin_channel u_first (
    .clk(clk),
    .rstn(rstn),
    .op(st_q.op_first),
    .setpoint(setpoint_first),
    .cfg(onoff_cfg),
    .en_pin(st_q.en_s2[0]),
    .uvlo_ok(st_q.uv_s2),
    .bus_owns_vout(bus_owns),
    .tick(st_q.tick),
    .ov_warn_clr(ov_warn_clr),
    .st(chan_first)
  );

  margin_channel u_second (
    .clk(clk),
    .rstn(rstn),
    .op(st_q.op_second),
    .setpoint(setpoint_second),
    .cfg(onoff_cfg),
    .en_pin(st_q.en_s2[1]),
    .uvlo_ok(st_q.uv_s2),
    .bus_owns_vout(bus_owns),
    .tick(st_q.tick),
    .ov_warn_clr(ov_warn_clr),
    .st(chan_second)
  );

endmodule // paged_operation_margin_control
`default_nettype wire

// File: dv/smbus_host.sv
`timescale 1ns/100ps
`default_nettype none
module smbus_host #(
  parameter logic [6:0] ADDR = opctl_pkg::DEV_ADDR_DEFAULT
) (
  input wire logic sda_oe,
  input wire logic sda_o,
  output logic scl,
  output logic sda_i
);
  logic sda_h = 1'b1;
  // Pull-up, so a released line reads high
  assign sda_i = sda_h & (~sda_oe | sda_o);
  initial scl = 1'b1;
  // Steps of 2.5 ns keep every change off the device clock edges
  task automatic bit_x(input logic b, output logic r);
    #12.5 sda_h = b;
    #50 scl = 1'b1;
    #30 r = sda_i;
    #32.5 scl = 1'b0;
  endtask
  // Start when s is high, stop otherwise
  task automatic cond(input logic s);
    #10 sda_h = s;
    #52.5 scl = 1'b1;
    #62.5 sda_h = ~s;
    #62.5 scl = ~s;
  endtask
  task automatic byte_x(input logic [7:0] d, output logic [7:0] q,
                        output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
      q[i] = r;
    end
    bit_x(1'b1, r);
    ack = ~r;
  endtask
  task automatic wr(input logic [7:0] cmd, input logic [7:0] d,
                    output logic ok);
    logic [7:0] q;
    logic a, b, c;
    cond(1'b1);
    byte_x({ADDR, 1'b0}, q, a);
    byte_x(cmd, q, b);
    byte_x(d, q, c);
    cond(1'b0);
    ok = a & b & c;
  endtask
  // Read Byte, host ends with NACK
  task automatic rd(input logic [7:0] cmd, output logic [7:0] d,
                    output logic ok);
    logic [7:0] q;
    logic a, b, c, n;
    cond(1'b1);
    byte_x({ADDR, 1'b0}, q, a);
    byte_x(cmd, q, b);
    cond(1'b1);
    byte_x({ADDR, 1'b1}, q, c);
    byte_x(8'hff, d, n);
    cond(1'b0);
    ok = a & b & c;
  endtask
endmodule // smbus_host
`default_nettype wire

// File: dv/opctl_properties.sv
`timescale 1ns/100ps
`default_nettype none
module opctl_properties #(
  parameter logic [6:0] DEV_ADDR = opctl_pkg::DEV_ADDR_DEFAULT
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic sda_oe,
  input wire logic first_channel_enable_pin,
  input wire logic uvlo_ok,
  input wire opctl_pkg::onoff_cfg_t onoff_cfg,
  input wire logic [7:0] voltage_control_source_select,
  input wire logic ov_warn_clr,
  input wire opctl_pkg::chan_out_t chan_first
);
  import opctl_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  logic [7:0] vt;
  logic no_bus;
  assign vt = chan_first.vout_target;
  assign no_bus = voltage_control_source_select != SRC_BUS;
  property p_reset;
    disable iff (1'b0) !rstn |=> chan_first == CHAN_RESET && !sda_oe;
  endproperty
  a_reset: assert property (p_reset)
    else $error("outputs not at reset state");
  property p_uv;
    (!uvlo_ok)[*4] |=> !chan_first.conv_on;
  endproperty
  a_uv: assert property (p_uv)
    else $error("conversion on below lockout");
  property p_pin;
    (onoff_cfg.use_pin && !first_channel_enable_pin)[*4]
      |=> !chan_first.conv_on;
  endproperty
  a_pin: assert property (p_pin)
    else $error("conversion on with pin low");
  property p_step;
    vt != $past(vt) |-> vt == $past(vt) + 8'h01 || vt == $past(vt) - 8'h01;
  endproperty
  a_step: assert property (p_step)
    else $error("target jumped");
  property p_space;
    vt != $past(vt) |=> $stable(vt)[*8];
  endproperty
  a_space: assert property (p_space)
    else $error("target stepped too fast");
  property p_fi;
    no_bus[*3] |=> !chan_first.fault_ignore;
  endproperty
  a_fi: assert property (p_fi)
    else $error("fault ignore without bus control");
  property p_clr;
    (ov_warn_clr && no_bus)[*2] |=> !chan_first.ov_warn;
  endproperty
  a_clr: assert property (p_clr)
    else $error("warning not cleared");
  property p_rose;
    $rose(chan_first.ov_warn) |-> !chan_first.fault_ignore;
  endproperty
  a_rose: assert property (p_rose)
    else $error("warning set while ignoring faults");
endmodule // opctl_properties
bind paged_operation_margin_control opctl_properties #(.DEV_ADDR(DEV_ADDR))
  chk (.clk(clk), .rstn(rstn), .sda_oe(sda_oe),
  .first_channel_enable_pin(first_channel_enable_pin), .uvlo_ok(uvlo_ok),
  .onoff_cfg(onoff_cfg),
  .voltage_control_source_select(voltage_control_source_select),
  .ov_warn_clr(ov_warn_clr), .chan_first(chan_first));
`default_nettype wire

// File: dv/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import opctl_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic scl, sda_i, sda_o, sda_oe;
  logic pin1 = 1'b0, pin2 = 1'b0, uvlo = 1'b0, clr = 1'b0;
  onoff_cfg_t cfg = '0;
  logic [7:0] src = 8'h00;
  setpoint_t sp1 = '{8'h08, 8'h04, 8'h0c};
  setpoint_t sp2 = '{8'h06, 8'h03, 8'h09};
  chan_out_t c1, c2;
  int n_fail = 0;
  int samples_checked = 0;
  always #5 clk = ~clk;
  smbus_host host (.sda_oe(sda_oe), .sda_o(sda_o), .scl(scl),
    .sda_i(sda_i));
  paged_operation_margin_control dut (.clk(clk), .rstn(rstn), .scl(scl),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
    .first_channel_enable_pin(pin1), .second_channel_enable_pin(pin2),
    .uvlo_ok(uvlo), .onoff_cfg(cfg), .voltage_control_source_select(src),
    .setpoint_first(sp1), .setpoint_second(sp2), .ov_warn_clr(clr),
    .chan_first(c1), .chan_second(c2));
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic op_wr(input logic [7:0] pg, input logic [7:0] d);
    logic okp, ok;
    // Host starts just after an edge
    @(posedge clk);
    #1;
    host.wr(CMD_PAGE, pg, okp);
    host.wr(CMD_OPERATION, d, ok);
    check("write ack", {7'h00, okp & ok}, 8'h01);
  endtask
  task automatic op_chk(input logic [7:0] pg, input logic [7:0] e);
    logic okp, ok;
    logic [7:0] d;
    @(posedge clk);
    #1;
    host.wr(CMD_PAGE, pg, okp);
    host.rd(CMD_OPERATION, d, ok);
    check("read ack", {7'h00, okp & ok}, 8'h01);
    check("operation", d, e);
  endtask
  task automatic t_regs;
    logic ok;
    logic [7:0] d;
    op_chk(PAGE_SECOND, OP_RESET);
    op_wr(PAGE_FIRST, 8'h80);
    op_wr(PAGE_SECOND, 8'hff);
    op_chk(PAGE_SECOND, 8'hbf);
    op_chk(PAGE_FIRST, 8'h80);
    op_wr(PAGE_BOTH, 8'h97);
    op_chk(PAGE_SECOND, 8'h97);
    op_chk(PAGE_FIRST, 8'h97);
    host.rd(CMD_PAGE, d, ok);
    check("page", d, PAGE_FIRST);
    host.wr(8'h02, 8'h00, ok);
    check("other cmd", {7'h00, ok}, 8'h00);
    $display("t_regs done");
  endtask
  task automatic t_onoff;
    logic [4:0] k;
    logic e;
    for (int i = 0; i < 32; i++) begin
      k = 5'(i);
      if (k[3:0] == 4'h0) op_wr(PAGE_BOTH, {k[4], 7'h00});
      @(posedge clk);
      {cfg, pin1, uvlo} <= k[3:0];
      pin2 <= k[1];
      e = k[0] & (!k[3] | k[4]) & (!k[2] | k[1]);
      repeat (6) @(posedge clk);
      #1;
      check("conv_on", 8'({c1.conv_on, c2.conv_on}),
            8'({e, e}));
    end
    $display("t_onoff done");
  endtask
  task automatic t_margin;
    logic [3:0] codes [7] = '{4'h0, 4'h5, 4'h6, 4'h9, 4'h3, 4'hc, 4'ha};
    logic [3:0] m;
    logic [7:0] e;
    logic w, fi;
    w = 1'b0;
    @(posedge clk);
    {cfg, uvlo} <= 3'b101;
    src <= SRC_BUS;
    for (int i = 0; i < 7; i++) begin
      m = codes[i];
      op_wr(PAGE_FIRST, {2'b10, m, 2'b00});
      repeat (1000) @(posedge clk);
      #1;
      e = (m == 4'h5 || m == 4'h6) ? sp1.margin_low :
          (m == 4'h9 || m == 4'ha) ? sp1.margin_high : sp1.nominal;
      fi = m == 4'h5 || m == 4'h9;
      w = w | (m == 4'ha);
      check("target", c1.vout_target, e);
      check("fi warn", 8'({c1.fault_ignore, c1.ov_warn}),
            8'({fi, w}));
      check("second target", c2.vout_target, sp2.nominal);
      check("fi2", 8'({c2.fault_ignore, c2.ov_warn}), 8'h00);
    end
    @(posedge clk);
    src <= 8'h00;
    clr <= 1'b1;
    repeat (1000) @(posedge clk);
    #1;
    check("source gate", c1.vout_target, sp1.nominal);
    check("warn clear", {7'h00, c1.ov_warn}, 8'h00);
    @(posedge clk);
    clr <= 1'b0;
    $display("t_margin done");
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (10) @(posedge clk);
    t_regs;
    t_onoff;
    t_margin;
    summarize;
  end
  // Whole run is near 230 us, so 500 us means a hang
  initial begin
    #500us;
    n_fail++;
    summarize;
  end
endmodule // testbench
`default_nettype wire
